// File: core/stmh_core.sv
// Message-phase decoder and READ status logic of a scanner bus target.
`timescale 1ns/10ps

// How it works
// - ABORT clears the sender's pending work and goes bus free; others keep theirs.
// - ABORT with no unit identified just goes bus free.
// - ABORT with nothing to clear raises no error.
// - Invalid or unexecutable messages are answered with MESSAGE REJECT.
// - Rejected COMMAND COMPLETE or nothing: bus free; rejected REJECT: CHECK CONDITION.
// - PARITY ERROR: resend in MESSAGE IN if ATN seen there, else bus free.
// - At most three resends; failing third retry goes straight to bus free.
// - BUS DEVICE RESET clears all work, sets unit attention for all, bus free.
// - BUS DEVICE RESET byte must arrive by asynchronous transfer.
// - Codes 80..FF are IDENTIFY; bit 5 set is rejected.
// - Overrunning READ gets CHECK CONDITION, IL set, info = requested minus left.
// - Other READs get GOOD; exact drain gives GOOD then CHECK next.
// - After all data is gone every READ gets CHECK until a new window.
// - After status the target sends COMMAND COMPLETE then goes bus free.
// - ATN sampled before phase changes, per message in MESSAGE OUT and IN.
module stmh_core
	import stmh_pkg::*;
#(
	parameter int NUM_INIT = 16,
	parameter int LEN_W = 24
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// Received message from the bus engine.
	input wire logic msg_valid,
	input wire stmh_msg_s msg,
	// Phase sequencer events.
	input wire logic status_done,
	input wire logic msgin_done,
	// READ sequence.
	input wire logic window_set,
	input wire logic [LEN_W-1:0] window_len,
	input wire logic read_valid,
	input wire logic [LEN_W-1:0] read_len,
	// Phase requests, one-cycle pulses.
	output logic go_bus_free,
	output logic send_reject,
	output logic resend_msg,
	output logic send_cmd_complete,
	output logic send_check,
	// Logical unit and initiator state.
	output logic lun_selected,
	output logic [NUM_INIT-1:0] pending,
	output logic [NUM_INIT-1:0] unit_attention,
	// READ answer.
	output logic read_done,
	output stmh_read_s read_result
);

	// Registered state; each register drives an output or a decision below.
	logic go_bus_free_q, send_reject_q, resend_msg_q, send_cc_q, send_check_q;
	logic lun_sel_q;
	logic [NUM_INIT-1:0] pending_q, ua_q;
	logic [1:0] retry_q;
	stmh_sent_e sent_q;
	logic [LEN_W-1:0] remain_q;
	logic drained_q;
	logic read_done_q;
	stmh_read_s read_q;

	// Message decode. The code fields are decoded once and shared. A sync-mode BUS DEVICE
	// RESET byte falls out of the known set and is rejected like any unsupported code.
	wire logic is_abort = msg_valid && msg.code == STMH_MSG_ABORT;
	wire logic is_rej = msg_valid && msg.code == STMH_MSG_REJECT;
	wire logic is_nop = msg_valid && msg.code == STMH_MSG_NOP;
	wire logic is_par = msg_valid && msg.code == STMH_MSG_PARITY_ERR;
	wire logic is_bdr_code = msg_valid && msg.code == STMH_MSG_BUS_DEV_RESET;
	wire logic is_bdr = is_bdr_code && !msg.sync_mode;
	wire logic is_ident = msg_valid && msg.code[STMH_IDENT_BIT];
	wire logic ident_bad = is_ident && msg.code[STMH_IDENT_PROC_BIT];
	wire logic known = is_abort || is_rej || is_nop || is_par || is_bdr || is_ident;
	// A sync-mode BDR byte counts as unexecutable and is rejected.
	wire logic reject_now = ident_bad || (msg_valid && !known);
	wire logic par_in_msgin = is_par && msg.atn_phase == STMH_PH_MSG_IN;
	wire logic retry_left = retry_q < STMH_MAX_RETRY;
	wire logic do_resend = par_in_msgin && retry_left && sent_q != STMH_SENT_NONE;
	wire logic rej_cc = is_rej && sent_q == STMH_SENT_CC;
	wire logic rej_rej = is_rej && sent_q == STMH_SENT_REJ;
	wire logic rej_none = is_rej && sent_q == STMH_SENT_NONE;
	wire logic [NUM_INIT-1:0] sender = NUM_INIT'(1) << msg.initiator;

	// Bus free requests. ABORT needs no unit and raises no error either way.
	wire logic free_d = is_abort || is_bdr || rej_cc || rej_none
		|| (is_par && !do_resend) || msgin_done;

	// READ decode against the remaining data count. Once the data is drained every READ is an
	// overrun, and the shortfall is then the whole request, since nothing is left to send.
	// A zero-length READ is never an overrun unless the data is already drained.
	wire logic overrun = read_valid && (drained_q || read_len > remain_q);
	wire logic [LEN_W-1:0] short_by = drained_q ? read_len : read_len - remain_q;

	// Phase request pulses. Each stands for a single cycle; the bus engine acts on it
	// and sends no acknowledge back.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			go_bus_free_q <= 1'b0;
			send_reject_q <= 1'b0;
			resend_msg_q <= 1'b0;
			send_cc_q <= 1'b0;
			send_check_q <= 1'b0;
		end else begin
			go_bus_free_q <= free_d;
			send_reject_q <= reject_now;
			resend_msg_q <= do_resend;
			send_cc_q <= status_done;
			send_check_q <= rej_rej;
		end
	end

	// Next retry count. A resend adds one; a fresh status, a reject or a bus free restarts it.
	// The count cannot pass the limit, because a resend is only ordered while retries are left.
	wire logic retry_clr = status_done || reject_now || free_d;
	wire logic [1:0] retry_d = do_resend ? retry_q + 2'h1
		: retry_clr ? 2'h0 : retry_q;

	// Next record of the last message sent. A bus free forgets it, so a REJECT that follows
	// is taken as one with no message issued and simply releases the bus.
	wire stmh_sent_e sent_d = free_d ? STMH_SENT_NONE
		: status_done ? STMH_SENT_CC
		: reject_now ? STMH_SENT_REJ : sent_q;

	// Next unit selection. A good IDENTIFY wins over a bus free that falls in the same cycle.
	wire logic ident_ok = is_ident && !ident_bad;
	wire logic lun_sel_d = ident_ok || (lun_sel_q && !free_d);

	// Next pending work. BUS DEVICE RESET clears the work of every initiator at once, while
	// ABORT clears only its sender, and only once a unit was identified.
	wire logic [NUM_INIT-1:0] pending_d = is_bdr ? {NUM_INIT{1'b0}}
		: (is_abort && lun_sel_q) ? pending_q & ~sender
		: ident_ok ? pending_q | sender : pending_q;

	// Unit attention is sticky; reporting and clearing it belongs to the sense logic.
	wire logic [NUM_INIT-1:0] ua_d = is_bdr ? {NUM_INIT{1'b1}} : ua_q;

	// Retry counter.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			retry_q <= 2'h0;
		end else begin
			retry_q <= retry_d;
		end
	end

	// Last message sent.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sent_q <= STMH_SENT_NONE;
		end else begin
			sent_q <= sent_d;
		end
	end

	// Unit selection flag.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			lun_sel_q <= 1'b0;
		end else begin
			lun_sel_q <= lun_sel_d;
		end
	end

	// Per-initiator pending work and unit attention.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pending_q <= '0;
			ua_q <= '0;
		end else begin
			pending_q <= pending_d;
			ua_q <= ua_d;
		end
	end

	// READ accounting. The window length reloads the remaining count. A window and a READ in
	// one cycle favour the window: the READ still gets its answer strobe, with the old result.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			remain_q <= '0;
			drained_q <= 1'b1;
			read_done_q <= 1'b0;
			read_q <= '0;
		end else begin
			read_done_q <= read_valid;
			if (window_set) begin
				remain_q <= window_len;
				drained_q <= 1'b0;
			end else if (read_valid) begin
				if (overrun) begin
					read_q.status <= STMH_ST_CHECK;
					read_q.ili <= 1'b1;
					read_q.info <= 24'(short_by);
					remain_q <= '0;
					drained_q <= 1'b1;
				end else begin
					read_q <= '{status: STMH_ST_GOOD, ili: 1'b0, info: 24'h000000};
					remain_q <= remain_q - read_len;
					drained_q <= read_len == remain_q;
				end
			end
		end
	end

	// Outputs straight from flip-flops.
	assign go_bus_free = go_bus_free_q;
	assign send_reject = send_reject_q;
	assign resend_msg = resend_msg_q;
	assign send_cmd_complete = send_cc_q;
	assign send_check = send_check_q;
	assign lun_selected = lun_sel_q;
	assign pending = pending_q;
	assign unit_attention = ua_q;
	assign read_done = read_done_q;
	assign read_result = read_q;

endmodule

// File: common/stmh_pkg.sv
// Package with message codes, status codes and carriers for the target message handler.
package stmh_pkg;

	// Message codes.
	localparam logic [7:0] STMH_MSG_CMD_COMPLETE = 8'h00;
	localparam logic [7:0] STMH_MSG_ABORT = 8'h06;
	localparam logic [7:0] STMH_MSG_REJECT = 8'h07;
	localparam logic [7:0] STMH_MSG_NOP = 8'h08;
	localparam logic [7:0] STMH_MSG_PARITY_ERR = 8'h09;
	localparam logic [7:0] STMH_MSG_BUS_DEV_RESET = 8'h0C;
	localparam int STMH_IDENT_BIT = 7;
	localparam int STMH_IDENT_PROC_BIT = 5;

	// Status codes, five-bit form.
	localparam logic [4:0] STMH_ST_GOOD = 5'h00;
	localparam logic [4:0] STMH_ST_CHECK = 5'h01;

	// Retry limit for MESSAGE IN resends.
	localparam logic [1:0] STMH_MAX_RETRY = 2'h3;

	// Last message the target sent.
	typedef enum logic [2:0] {
		STMH_SENT_NONE = 3'b001,
		STMH_SENT_CC = 3'b010,
		STMH_SENT_REJ = 3'b100
	} stmh_sent_e;

	// Phase in which ATN was seen.
	typedef enum logic [1:0] {
		STMH_PH_MSG_IN = 2'b01,
		STMH_PH_OTHER = 2'b10
	} stmh_phase_e;

	// One received message byte.
	typedef struct packed {
		logic [7:0] code;
		logic [3:0] initiator;
		logic sync_mode;
		logic [1:0] atn_phase;
	} stmh_msg_s;

	// Outcome of one READ command.
	typedef struct packed {
		logic [4:0] status;
		logic ili;
		logic [23:0] info;
	} stmh_read_s;

endpackage

// File: tb/stmh_init_model.sv
// Behavioural bus initiator that hands message bytes to the target.
`timescale 1ns/10ps
module stmh_init_model
	import stmh_pkg::*;
(
	// Clock.
	input wire logic clock,
	// Message byte towards the target.
	output logic msg_valid,
	output stmh_msg_s msg
);
	// One byte per call, dropped before the next starts; released data is inverted, not held.
	task automatic send(input logic [7:0] c, input logic [3:0] i, input logic s,
		input logic [1:0] p);
		@(posedge clock);
		#1 msg_valid = 1'b1;
		msg = '{c, i, s, p};
		@(posedge clock);
		#1 msg_valid = 1'b0;
		msg = ~msg;
	endtask
endmodule

// File: tb/stmh_core_properties.sv
// Port checker for the target message handler.
`timescale 1ns/10ps
module stmh_core_properties
	import stmh_pkg::*;
#(parameter int NUM_INIT = 16) (
	// Watched ports.
	input wire logic clock,
	input wire logic rst,
	input wire logic msg_valid,
	input wire stmh_msg_s msg,
	input wire logic status_done,
	input wire logic read_valid,
	input wire logic go_bus_free,
	input wire logic send_reject,
	input wire logic resend_msg,
	input wire logic send_cmd_complete,
	input wire logic [NUM_INIT-1:0] pending,
	input wire logic [NUM_INIT-1:0] unit_attention,
	input wire logic read_done
);
	// Single domain, so clock and reset are given once.
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// Byte decodes shared by the checks.
	wire logic bdr = msg_valid && msg.code == 8'h0C;
	wire logic par = msg_valid && msg.code == 8'h09;
	a_abort_free: assert property (msg_valid && msg.code == 8'h06 |=> go_bus_free)
		else $error("abort kept the bus");
	a_reset_all: assert property (bdr && !msg.sync_mode |=>
		go_bus_free && &unit_attention && pending == '0) else $error("device reset incomplete");
	a_sync_reset: assert property (bdr && msg.sync_mode |=> send_reject)
		else $error("synchronous device reset accepted");
	a_ident_proc: assert property (msg_valid && msg.code[7] && msg.code[5] |=> send_reject)
		else $error("process identify accepted");
	a_odd_code: assert property (msg_valid && msg.code[7:4] == 4'h4 |=> send_reject)
		else $error("unknown code accepted");
	a_parity_out: assert property (par && msg.atn_phase == 2'h2 |=> go_bus_free)
		else $error("parity outside message in kept the bus");
	a_status_cc: assert property (status_done |=> send_cmd_complete)
		else $error("no complete after status");
	a_read_answer: assert property (read_valid |=> read_done)
		else $error("read not answered");
	// Main scenarios reached.
	c_resend: cover property (resend_msg);
	c_attention: cover property (&unit_attention);
	c_parity: cover property (par ##1 resend_msg);
	c_reject: cover property (msg_valid ##1 send_reject);
endmodule

// File: tb/stmh_core_tb.sv
// Self-checking bench for the target message handler.
`timescale 1ns/10ps
module stmh_core_tb;
	import stmh_pkg::*;
	logic clock, rst, status_done, msgin_done, window_set, read_valid, msg_valid, lun_selected;
	logic go_bus_free, send_reject, resend_msg, send_cmd_complete, send_check, read_done;
	logic [23:0] window_len, read_len, left;
	logic [15:0] pending, unit_attention;
	stmh_msg_s msg;
	stmh_read_s read_result;
	int failures, checks, cyc;
	wire logic [3:0] outs = {go_bus_free, send_reject, resend_msg, send_check};
	stmh_core i_dut (.clock, .rst, .msg_valid, .msg, .status_done, .msgin_done, .window_set,
		.window_len, .read_valid, .read_len, .go_bus_free, .send_reject, .resend_msg,
		.send_cmd_complete, .send_check, .lun_selected, .pending, .unit_attention, .read_done,
		.read_result);
	stmh_init_model i_ini (.clock, .msg_valid, .msg);
	// Compare, count and report.
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e)
			$display("BAD %s expected %0h seen %0h", n, e, s);
		if (s !== e)
			failures++;
	endtask
	task automatic summarize;
		if (failures == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic pulse(ref logic s);
		@(posedge clock);
		#1 s = 1'b1;
		@(posedge clock);
		#1 s = 1'b0;
	endtask
	// One byte in, then the phase request of the following cycle. Bytes come from initiator 3
	// by default, with ATN seen outside MESSAGE IN and an asynchronous transfer.
	task automatic mx(input logic [7:0] c, input logic [3:0] e, input logic [3:0] i = 4'h3,
		input logic [1:0] p = 2'h2, input logic s = 1'b0);
		i_ini.send(c, i, s, p);
		chk("phase request", outs, e);
	endtask
	// Expected READ answer from the data left: an overrun reports the shortfall.
	function automatic logic [29:0] exp_read(input logic [23:0] n, input logic [23:0] l);
		exp_read = (n > l) ? {STMH_ST_CHECK, 1'b1, n - l} : {STMH_ST_GOOD, 1'b0, 24'h000000};
	endfunction
	// An overrun leaves nothing to read until the next window.
	task automatic rd(input logic [23:0] n);
		read_len = n;
		pulse(read_valid);
		chk("read strobe", read_done, 32'h1);
		chk("read", read_result, exp_read(n, left));
		left = (n > left) ? 24'h0 : left - n;
	endtask
	task automatic win(input logic [23:0] n);
		window_len = n;
		left = n;
		pulse(window_set);
	endtask
	// Clock and hang limit.
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc++;
		if (cyc == 4000) begin
			failures++;
			summarize();
		end
	end
	// Main sequence.
	initial begin
		{rst, status_done, msgin_done, window_set, read_valid, window_len, read_len} = 53'h0;
		rst = 1'b1;
		left = 24'h0;
		i_ini.msg_valid = 1'b0;
		i_ini.msg = '0;
		void'($urandom(18435));
		repeat (20) @(posedge clock);
		#1 rst = 1'b0;
		rd(24'h5);
		win(24'h64);
		rd(24'h3C);
		rd(24'h28);
		rd(24'hA);
		repeat (8) begin
			win($urandom_range(1, 400));
			repeat (3) rd($urandom_range(1, 200));
		end
		mx(8'h07, 4'h8);
		pulse(status_done);
		mx(8'h07, 4'h8);
		mx(8'h42, 4'h4);
		mx(8'h07, 4'h1);
		mx(8'h08, 4'h0);
		pulse(status_done);
		chk("complete", send_cmd_complete, 32'h1);
		mx(8'h09, 4'h8);
		pulse(status_done);
		repeat (3) mx(8'h09, 4'h2, 4'h3, 2'h1);
		mx(8'h09, 4'h8, 4'h3, 2'h1);
		mx(8'hA0, 4'h4);
		mx(8'h80, 4'h0);
		mx(8'hC1, 4'h0, 4'h5);
		mx(8'h06, 4'h8);
		chk("pending", {lun_selected, pending}, 32'h20);
		mx(8'h06, 4'h8);
		mx(8'h0C, 4'h4, 4'h5, 2'h2, 1'b1);
		mx(8'h0C, 4'h8, 4'h5);
		chk("attention", unit_attention, 32'hFFFF);
		pulse(status_done);
		pulse(msgin_done);
		chk("release", go_bus_free, 32'h1);
		summarize();
	end
endmodule
bind stmh_core stmh_core_properties #(.NUM_INIT(NUM_INIT)) i_prop (.clock, .rst, .msg_valid,
	.msg, .status_done, .read_valid, .go_bus_free, .send_reject, .resend_msg,
	.send_cmd_complete, .pending, .unit_attention, .read_done);
